// ### design/radio_status_pkg.sv
/*
 Constants, offsets and carrier types for the radio status register bank.
 Assumes a single 50 MHz clock shared with the radio core that feeds it.
*/
package radio_status_pkg;
   // Access header layout
   localparam int HDR_READ_BIT  = 7;
   localparam int HDR_BURST_BIT = 6;
   localparam logic [7:0] HDR_REPLY = 8'h00;
   // Register offsets
   localparam logic [5:0] OFS_SYNTH_TEST  = 6'h2e;
   localparam logic [5:0] OFS_PART_ID     = 6'h30;
   localparam logic [5:0] OFS_VERSION     = 6'h31;
   localparam logic [5:0] OFS_FREQ_EST    = 6'h32;
   localparam logic [5:0] OFS_LINK_QUAL   = 6'h33;
   localparam logic [5:0] OFS_SIG_STR     = 6'h34;
   localparam logic [5:0] OFS_CTRL_STATE  = 6'h35;
   localparam logic [5:0] OFS_WAKE_HIGH   = 6'h36;
   localparam logic [5:0] OFS_WAKE_LOW    = 6'h37;
   localparam logic [5:0] OFS_PKT_STATUS  = 6'h38;
   localparam logic [5:0] OFS_SYNTH_DAC   = 6'h39;
   localparam logic [5:0] OFS_TX_FILL     = 6'h3a;
   localparam logic [5:0] OFS_RX_FILL     = 6'h3b;
   localparam logic [5:0] OFS_RC_HIGH     = 6'h3c;
   localparam logic [5:0] OFS_RC_LOW      = 6'h3d;
   // Test register
   localparam logic [7:0] SYNTH_TEST_RESET = 8'h0b;
   localparam int         OSC_CAL_BIT      = 1;
   // Control state codes
   localparam logic [4:0] CODE_SLEEP = 5'h00;
   localparam logic [4:0] CODE_IDLE  = 5'h01;
   localparam logic [4:0] CODE_CRYSTAL_OFF_STATE  = 5'h02;
   localparam logic [7:0] ZERO_BYTE  = 8'h00;
   localparam int         LQI_SYMBOLS_DEF = 64;

   typedef enum logic [1:0] {PH_IDLE, PH_HEADER, PH_DATA} phase_type;

   typedef struct packed {
      logic [7:0]  carrier_offset_value;
      logic        ook_mode;
      logic        legacy_packet_compat;
      logic        crc_done;
      logic        crc_match;
      logic        rx_entry;
      logic        sync_found;
      logic        symbol_strobe;
      logic [6:0]  symbol_quality;
      logic [7:0]  signal_strength;
      logic [4:0]  control_state_code;
      logic [15:0] wake_timer;
      logic        carrier_sense;
      logic        preamble_quality_flag;
      logic        channel_clear_flag;
      logic        sync_found_flag;
      logic        output_pin_two;
      logic        output_pin_zero;
      logic [7:0]  synth_dac;
      logic        tx_queue_underrun;
      logic [6:0]  tx_byte_count;
      logic        rx_queue_overrun;
      logic [6:0]  rx_byte_count;
      logic [6:0]  rc_cal_result_high;
      logic [6:0]  rc_cal_result_low;
   } radio_status_type;

   typedef struct packed {
      logic       strobe_valid;
      logic [5:0] strobe_code;
      logic       idle_request;
      logic       offset_comp_enable;
      logic       osc_select_cal_enable;
   } radio_ctrl_type;
endpackage

// ### design/radio_status_register_bank.sv
/*
 Status register bank with its serial configuration port (mode 0, MSB first).
 Assumes the radio core drives the status struct on ref_clk and that the
 serial clock is well below a quarter of ref_clk, since pins are oversampled.
*/
// Functional notes
// - Frequency offset estimate is an 8-bit two's complement byte.
// - Frequency offset reads zero while on-off keying is selected.
// - Offset compensation enabled only for FSK, GFSK and MSK.
// - Checksum flag sets on a match, clears on receive entry or a checksum mismatch.
// - Checksum flag only updated when legacy packet compatibility is one.
// - Link quality is averaged over the 64 symbols after sync.
// - Signal strength is an 8-bit read-only status byte.
// - Control state reported as a 5-bit code, upper bits zero.
// - Sleep and crystal-off codes never read; chip select forces idle.
// - Wake timer exposed as read-only high and low bytes.
// - Packet status bits: checksum, carrier, preamble, clear, sync, pins.
// - Pin bits show the non-inverted internal output values.
// - Transmit fill byte: underflow in bit 7, count in bits 6:0.
// - Receive fill byte: overflow in bit 7, count in bits 6:0.
// - Two RC calibration results, seven bits each, bit 7 zero.
// - Synthesizer DAC byte is read-only test status only.
// - Fixed part identifier and version bytes are read-only.
// - Test register bit 1 enables oscillator selection calibration, reset 1.
`timescale 1ns/1ns
`default_nettype none
module radio_status_register_bank #(
   parameter logic [7:0] PART_ID     = 8'h5a, // Arbitrary value
   parameter logic [7:0] VERSION_ID  = 8'h01, // Arbitrary value
   parameter int         LQI_SYMBOLS = radio_status_pkg::LQI_SYMBOLS_DEF
) (
   // Clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       rst,
   // Serial port pins
   input  wire logic                       sclk,
   input  wire logic                       chip_select_n,
   input  wire logic                       mosi,
   output logic                            miso_out,
   output logic                            miso_oe_n,
   // Radio core
   input  wire radio_status_pkg::radio_status_type stat,
   output radio_status_pkg::radio_ctrl_type        ctrl
);
   import radio_status_pkg::*;

   localparam int LQI_SHIFT = $clog2(LQI_SYMBOLS);
   localparam int SUM_W     = 7 + LQI_SHIFT;
   localparam logic [LQI_SHIFT:0] SYM_LAST = (LQI_SHIFT+1)'(LQI_SYMBOLS - 1);

   // Pin synchronisers
   logic [2:0] sclk_q;
   logic [2:0] csn_q;
   logic [1:0] mosi_q;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       csn_fall;
   logic       csn_high;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         sclk_q <= 3'h0;
         csn_q  <= 3'h7;
         mosi_q <= 2'h0;
      end
      else
      begin
         sclk_q <= {sclk_q[1:0], sclk};
         csn_q  <= {csn_q[1:0], chip_select_n};
         mosi_q <= {mosi_q[0], mosi};
      end
   end

   assign sclk_rise = sclk_q[1] & ~sclk_q[2];
   assign sclk_fall = ~sclk_q[1] & sclk_q[2];
   assign csn_fall  = ~csn_q[1] & csn_q[2];
   assign csn_high  = csn_q[1];

   // Checksum flag
   logic crc_ok_r;
   logic crc_set;

   assign crc_set = stat.crc_done & stat.crc_match;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         crc_ok_r <= 1'b0;
      else if (stat.legacy_packet_compat)
      begin
         if (crc_set)
            crc_ok_r <= 1'b1;
         else if (stat.rx_entry || stat.crc_done)
            crc_ok_r <= 1'b0;
      end
   end

   // Link quality averaging; a new sync restarts the window
   logic                 lqi_busy_r;
   logic [LQI_SHIFT:0]   sym_cnt_r;
   logic [SUM_W-1:0]     lqi_sum_r;
   logic [6:0]           lqi_r;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         lqi_busy_r <= 1'b0;
         sym_cnt_r  <= '0;
         lqi_sum_r  <= '0;
         lqi_r      <= 7'h00;
      end
      else if (stat.sync_found)
      begin
         lqi_busy_r <= 1'b1;
         sym_cnt_r  <= '0;
         lqi_sum_r  <= '0;
      end
      else if (lqi_busy_r && stat.symbol_strobe)
      begin
         if (sym_cnt_r == SYM_LAST)
         begin
            lqi_busy_r <= 1'b0;
            lqi_r      <= 7'((lqi_sum_r + SUM_W'(stat.symbol_quality)) >> LQI_SHIFT);
         end
         else
         begin
            sym_cnt_r <= sym_cnt_r + 1'b1;
            lqi_sum_r <= lqi_sum_r + SUM_W'(stat.symbol_quality);
         end
      end
   end

   // Test register
   logic [7:0] synth_test_r;
   logic [7:0] synth_test_nxt;
   logic       test_wr;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         synth_test_r <= SYNTH_TEST_RESET;
      else if (test_wr)
         synth_test_r <= synth_test_nxt;
   end

   // Read multiplexer; pure function of state, so reads change nothing
   function automatic logic [7:0] read_byte(input logic [5:0] a);
      logic [7:0] v;
      v = ZERO_BYTE;
      unique case (a)
         OFS_PART_ID:    v = PART_ID;
         OFS_VERSION:    v = VERSION_ID;
         OFS_FREQ_EST:   v = stat.ook_mode ? ZERO_BYTE : stat.carrier_offset_value;
         OFS_LINK_QUAL:  v = {crc_ok_r, lqi_r};
         OFS_SIG_STR:    v = stat.signal_strength;
         OFS_CTRL_STATE:
         begin
            // Sleep and crystal-off are left as soon as select falls
            if (stat.control_state_code == CODE_SLEEP ||
                stat.control_state_code == CODE_CRYSTAL_OFF_STATE)
               v = {3'h0, CODE_IDLE};
            else
               v = {3'h0, stat.control_state_code};
         end
         OFS_WAKE_HIGH:  v = stat.wake_timer[15:8];
         OFS_WAKE_LOW:   v = stat.wake_timer[7:0];
         OFS_PKT_STATUS: v = {crc_ok_r, stat.carrier_sense, stat.preamble_quality_flag,
                              stat.channel_clear_flag, stat.sync_found_flag,
                              stat.output_pin_two, 1'b0, stat.output_pin_zero};
         OFS_SYNTH_DAC:  v = stat.synth_dac;
         OFS_TX_FILL:    v = {stat.tx_queue_underrun, stat.tx_byte_count};
         OFS_RX_FILL:    v = {stat.rx_queue_overrun, stat.rx_byte_count};
         OFS_RC_HIGH:    v = {1'b0, stat.rc_cal_result_high};
         OFS_RC_LOW:     v = {1'b0, stat.rc_cal_result_low};
         OFS_SYNTH_TEST: v = synth_test_r;
         default:        v = ZERO_BYTE;
      endcase
      return v;
   endfunction

   // Serial engine
   phase_type  phase_r;
   logic [2:0] bit_cnt_r;
   logic [7:0] rx_shift_r;
   logic [7:0] tx_shift_r;
   logic [5:0] addr_r;
   logic       rd_r;
   logic       burst_r;
   logic       miso_r;
   logic       byte_done;
   logic [7:0] rx_byte;
   logic [5:0] next_addr;
   logic       status_addr;
   logic       strobe_hit;

   assign byte_done = sclk_rise && (bit_cnt_r == 3'h7) && !csn_high;
   assign rx_byte   = {rx_shift_r[6:0], mosi_q[1]};
   assign next_addr = (phase_r == PH_HEADER) ? rx_byte[5:0] : addr_r + 6'h01;
   assign status_addr = (rx_byte[5:0] >= OFS_PART_ID);
   assign strobe_hit  = byte_done && (phase_r == PH_HEADER) && status_addr
                        && !rx_byte[HDR_BURST_BIT];
   assign test_wr     = byte_done && (phase_r == PH_DATA) && !rd_r
                        && (addr_r == OFS_SYNTH_TEST);
   assign synth_test_nxt = rx_byte;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         phase_r    <= PH_IDLE;
         bit_cnt_r  <= 3'h0;
         rx_shift_r <= 8'h00;
         addr_r     <= 6'h00;
         rd_r       <= 1'b0;
         burst_r    <= 1'b0;
      end
      else if (csn_high)
      begin
         phase_r   <= PH_IDLE;
         bit_cnt_r <= 3'h0;
      end
      else
      begin
         unique case (phase_r)
            PH_IDLE:
               phase_r <= PH_HEADER;
            PH_HEADER, PH_DATA:
            begin
               if (sclk_rise)
               begin
                  rx_shift_r <= rx_byte;
                  bit_cnt_r  <= bit_cnt_r + 3'h1;
               end
               if (byte_done)
               begin
                  if (phase_r == PH_HEADER)
                  begin
                     rd_r    <= rx_byte[HDR_READ_BIT];
                     burst_r <= rx_byte[HDR_BURST_BIT];
                     addr_r  <= next_addr;
                     // A plain header to a status offset is a strobe
                     phase_r <= strobe_hit ? PH_HEADER : PH_DATA;
                  end
                  else if (burst_r)
                     addr_r <= next_addr;
               end
            end
         endcase
      end
   end

   // Output shifter; first bit is set up before the first rising edge
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         tx_shift_r <= 8'h00;
         miso_r     <= 1'b0;
      end
      else if (csn_fall)
      begin
         miso_r     <= HDR_REPLY[7];
         tx_shift_r <= {HDR_REPLY[6:0], 1'b0};
      end
      else if (byte_done)
         tx_shift_r <= read_byte(next_addr);
      else if (sclk_fall && !csn_high)
      begin
         miso_r     <= tx_shift_r[7];
         tx_shift_r <= {tx_shift_r[6:0], 1'b0};
      end
   end

   // Control outputs towards the radio core
   logic       strobe_r;
   logic [5:0] strobe_code_r;
   logic       idle_req_r;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         strobe_r      <= 1'b0;
         strobe_code_r <= 6'h00;
         idle_req_r    <= 1'b0;
      end
      else
      begin
         strobe_r   <= strobe_hit;
         idle_req_r <= csn_fall;
         if (strobe_hit)
            strobe_code_r <= rx_byte[5:0];
      end
   end

   assign miso_out  = miso_r;
   assign miso_oe_n = csn_high;
   assign ctrl.strobe_valid          = strobe_r;
   assign ctrl.strobe_code           = strobe_code_r;
   assign ctrl.idle_request          = idle_req_r;
   assign ctrl.offset_comp_enable    = ~stat.ook_mode;
   assign ctrl.osc_select_cal_enable = synth_test_r[OSC_CAL_BIT];

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_sync_start;
      stat.sync_found;
   endsequence

   sequence s_window_end;
      lqi_busy_r && stat.symbol_strobe && !stat.sync_found && sym_cnt_r == SYM_LAST;
   endsequence

   a_foe_ook_zero: assert property (
      stat.ook_mode |-> read_byte(OFS_FREQ_EST) == ZERO_BYTE)
      else $error("offset not zero in ook");

   a_comp_ook_off: assert property (
      ctrl.offset_comp_enable == !stat.ook_mode)
      else $error("compensation active in ook");

   a_crc_set_wins: assert property (
      stat.legacy_packet_compat && crc_set |=> (read_byte(OFS_LINK_QUAL) & 8'h80) == 8'h80)
      else $error("checksum flag not set");

   a_crc_rx_clear: assert property (
      stat.legacy_packet_compat && stat.rx_entry && !crc_set |=> !crc_ok_r)
      else $error("checksum flag not cleared");

   a_crc_compat_hold: assert property (
      !stat.legacy_packet_compat |=> $stable(crc_ok_r))
      else $error("checksum flag moved without compat");

   a_lqi_start_busy: assert property (
      s_sync_start |=> lqi_busy_r && sym_cnt_r == '0 && lqi_sum_r == '0)
      else $error("lqi window not restarted");

   // Last symbol closes the window and publishes the average including itself
   a_lqi_window_end: assert property (
      s_window_end |=> !lqi_busy_r &&
         lqi_r == 7'(($past(lqi_sum_r) + SUM_W'($past(stat.symbol_quality))) >> LQI_SHIFT))
      else $error("lqi window did not close");

   a_state_no_sleep: assert property (
      read_byte(OFS_CTRL_STATE) != {3'h0, CODE_SLEEP} &&
      read_byte(OFS_CTRL_STATE) != {3'h0, CODE_CRYSTAL_OFF_STATE})
      else $error("sleep or crystal-off code visible");

   a_pin_status_map: assert property (
      (read_byte(OFS_PKT_STATUS) & 8'h7f) == {1'b0, stat.carrier_sense,
         stat.preamble_quality_flag, stat.channel_clear_flag, stat.sync_found_flag,
         stat.output_pin_two, 1'b0, stat.output_pin_zero})
      else $error("packet status bits misplaced");

   a_ro_write_ignored: assert property (
      byte_done && phase_r == PH_DATA && addr_r != OFS_SYNTH_TEST |=> $stable(synth_test_r))
      else $error("read-only write took effect");

   a_cal_bit_drive: assert property (
      test_wr |=> ctrl.osc_select_cal_enable == $past(rx_byte[OSC_CAL_BIT]))
      else $error("calibration enable not steered");

   a_miso_release: assert property (
      csn_high |-> miso_oe_n)
      else $error("miso driven without select");

   a_burst_addr_step: assert property (
      byte_done && phase_r == PH_DATA && burst_r |=> addr_r == $past(addr_r) + 6'h01)
      else $error("burst address did not advance");

   a_strobe_pulse: assert property (
      strobe_hit |=> ctrl.strobe_valid && ctrl.strobe_code == $past(rx_byte[5:0]))
      else $error("strobe not forwarded");
endmodule
`default_nettype wire

// ### tb/host_spi_model.sv
/*
 Host side model of the serial port: mode 0 master, MSB first.
 Assumes ref_clk is the device clock; one sclk half period is five of its cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module host_spi_model (
   // Clock
   input  wire logic ref_clk,
   // Serial pins
   output var logic  sclk,
   output var logic  chip_select_n,
   output var logic  mosi,
   input  wire logic miso_out,
   input  wire logic miso_oe_n
);
   localparam int HALF = 5; // Keeps each half period above four device cycles
   logic [7:0] hdr_rx;
   logic       miso_last;
   initial
   begin
      sclk = 1'b0;
      chip_select_n = 1'b1;
      mosi = 1'b0;
      hdr_rx = 8'h00;
      miso_last = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         mosi = tx[i];
         tick(HALF);
         sclk = 1'b1;
         // Undriven line reads as the inverse of the last bit, never a lucky zero
         rx[i] = miso_oe_n ? ~miso_last : miso_out;
         miso_last = rx[i];
         tick(HALF);
         sclk = 1'b0;
      end
   endtask
   // Header then at most one data byte; pin bits are never polled for lock
   task automatic frame(input logic [7:0] hdr, input logic [7:0] wd, input int n,
                        output logic [7:0] rd);
      rd = 8'h00;
      chip_select_n = 1'b0;
      tick(4);
      xfer(hdr, hdr_rx);
      if (n > 0)
         xfer(wd, rd);
      tick(HALF);
      chip_select_n = 1'b1;
      mosi = ~mosi;
      tick(8);
   endtask
   // Header then two read bytes in one burst, so the address must step
   task automatic burst_pair(input logic [7:0] hdr, output logic [7:0] rd_a,
                             output logic [7:0] rd_b);
      chip_select_n = 1'b0;
      tick(4);
      xfer(hdr, hdr_rx);
      xfer(8'h00, rd_a);
      xfer(8'h00, rd_b);
      tick(HALF);
      chip_select_n = 1'b1;
      mosi = ~mosi;
      tick(8);
   endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
/*
 Self-checking bench for the status register bank, driving the radio core side.
 Assumes the host model for the serial pins and a 50 MHz ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import radio_status_pkg::*;
   localparam logic [7:0] PART_T = 8'h5a; // Arbitrary value
   localparam logic [7:0] VER_T  = 8'h01; // Arbitrary value
   localparam int         LQI_N  = 4;     // Shortened symbol count
   logic ref_clk, rst, sclk, chip_select_n, mosi, miso_out, miso_oe_n;
   radio_status_type stat;
   radio_ctrl_type   ctrl;
   int bad_count, tests_run, s0;
   int strobe_hits = 0;
   int idle_hits = 0;
   logic [7:0] rd;
   radio_status_register_bank #(.PART_ID(PART_T), .VERSION_ID(VER_T), .LQI_SYMBOLS(LQI_N))
      i_radio_status_register_bank (.ref_clk(ref_clk), .rst(rst), .sclk(sclk),
      .chip_select_n(chip_select_n), .mosi(mosi), .miso_out(miso_out),
      .miso_oe_n(miso_oe_n), .stat(stat), .ctrl(ctrl));
   host_spi_model i_host_spi_model (.ref_clk(ref_clk), .sclk(sclk),
      .chip_select_n(chip_select_n), .mosi(mosi), .miso_out(miso_out),
      .miso_oe_n(miso_oe_n));
   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      strobe_hits <= strobe_hits + int'(ctrl.strobe_valid);
      idle_hits   <= idle_hits + int'(ctrl.idle_request);
   end
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      check_byte({7'h00, got}, {7'h00, exp});
   endtask
   task automatic rd_reg(input logic [5:0] ofs);
      i_host_spi_model.frame({2'b11, ofs}, 8'h00, 1, rd);
   endtask
   task automatic rd_chk(input logic [5:0] ofs, input logic [7:0] exp);
      rd_reg(ofs);
      check_byte(rd, exp);
   endtask
   task automatic wr_reg(input logic [7:0] hdr, input logic [7:0] wd);
      i_host_spi_model.frame(hdr, wd, 1, rd);
   endtask
   task automatic pulse_crc(input logic match);
      stat.crc_done = 1'b1;
      stat.crc_match = match;
      tick();
      stat.crc_done = 1'b0;
   endtask
   task automatic test_reset();
      check_bit(miso_oe_n, 1'b1);
      check_bit(ctrl.osc_select_cal_enable, 1'b1);
      rd_chk(OFS_SYNTH_TEST, SYNTH_TEST_RESET);
      check_byte(i_host_spi_model.hdr_rx, HDR_REPLY);
      wr_reg({2'b00, OFS_SYNTH_TEST}, 8'h09);
      check_bit(ctrl.osc_select_cal_enable, 1'b0);
      rd_chk(OFS_SYNTH_TEST, 8'h09);
      wr_reg({2'b00, OFS_SYNTH_TEST}, 8'h0b);
      check_bit(ctrl.osc_select_cal_enable, 1'b1);
      $display("test reset done");
   endtask
   task automatic test_ids();
      rd_chk(OFS_PART_ID, PART_T);
      rd_chk(OFS_VERSION, VER_T);
      $display("test ids done");
   endtask
   task automatic test_freq();
      stat.carrier_offset_value = 8'h9c;
      stat.ook_mode = 1'b0;
      rd_chk(OFS_FREQ_EST, 8'h9c);
      check_bit(ctrl.offset_comp_enable, 1'b1);
      stat.ook_mode = 1'b1;
      rd_chk(OFS_FREQ_EST, ZERO_BYTE);
      check_bit(ctrl.offset_comp_enable, 1'b0);
      stat.ook_mode = 1'b0;
      $display("test freq done");
   endtask
   task automatic test_fields();
      logic [7:0] hi;
      logic [7:0] lo;
      stat.signal_strength = 8'ha5;
      stat.wake_timer = 16'h1234;
      {stat.carrier_sense, stat.preamble_quality_flag, stat.channel_clear_flag} = 3'b101;
      {stat.sync_found_flag, stat.output_pin_two, stat.output_pin_zero} = 3'b010;
      stat.synth_dac = 8'h6e;
      {stat.tx_queue_underrun, stat.tx_byte_count} = 8'hc5;
      {stat.rx_queue_overrun, stat.rx_byte_count} = 8'h3f;
      stat.rc_cal_result_high = 7'h7f;
      stat.rc_cal_result_low = 7'h01;
      rd_chk(OFS_SIG_STR, 8'ha5);
      rd_chk(OFS_WAKE_HIGH, 8'h12);
      rd_chk(OFS_WAKE_LOW, 8'h34);
      i_host_spi_model.burst_pair({2'b11, OFS_WAKE_HIGH}, hi, lo);
      check_byte(hi, 8'h12);
      check_byte(lo, 8'h34);
      rd_chk(OFS_PKT_STATUS, 8'h54);
      rd_chk(OFS_SYNTH_DAC, 8'h6e);
      rd_chk(OFS_TX_FILL, 8'hc5);
      rd_chk(OFS_RX_FILL, 8'h3f);
      rd_chk(OFS_RC_HIGH, 8'h7f);
      rd_chk(OFS_RC_LOW, 8'h01);
      {stat.carrier_sense, stat.preamble_quality_flag, stat.channel_clear_flag} = 3'b010;
      {stat.sync_found_flag, stat.output_pin_two, stat.output_pin_zero} = 3'b101;
      {stat.tx_queue_underrun, stat.tx_byte_count} = 8'h40;
      {stat.rx_queue_overrun, stat.rx_byte_count} = 8'h80;
      rd_chk(OFS_PKT_STATUS, 8'h29);
      rd_chk(OFS_TX_FILL, 8'h40);
      rd_chk(OFS_RX_FILL, 8'h80);
      $display("test fields done");
   endtask
   task automatic test_states();
      logic [4:0] exp;
      s0 = idle_hits;
      for (int c = 0; c <= 22; c++)
      begin
         stat.control_state_code = 5'(c);
         exp = (c == 0 || c == 2) ? CODE_IDLE : 5'(c);
         rd_chk(OFS_CTRL_STATE, {3'b000, exp});
      end
      check_byte(8'(idle_hits - s0), 8'h17);
      $display("test states done");
   endtask
   task automatic test_crc();
      stat.legacy_packet_compat = 1'b1;
      pulse_crc(1'b1);
      rd_reg(OFS_LINK_QUAL);
      check_bit(rd[7], 1'b1);
      rd_reg(OFS_PKT_STATUS);
      check_bit(rd[7], 1'b1);
      stat.rx_entry = 1'b1;
      tick();
      stat.rx_entry = 1'b0;
      rd_reg(OFS_LINK_QUAL);
      check_bit(rd[7], 1'b0);
      stat.legacy_packet_compat = 1'b0;
      pulse_crc(1'b1);
      rd_reg(OFS_PKT_STATUS);
      check_bit(rd[7], 1'b0);
      $display("test crc done");
   endtask
   task automatic test_lqi();
      logic [6:0] q [2] = '{7'h2a, 7'h11};
      for (int k = 0; k < 2; k++)
      begin
         stat.symbol_quality = q[k];
         stat.sync_found = 1'b1;
         tick();
         stat.sync_found = 1'b0;
         repeat (LQI_N)
         begin
            tick();
            stat.symbol_strobe = 1'b1;
            tick();
            stat.symbol_strobe = 1'b0;
         end
         rd_reg(OFS_LINK_QUAL);
         check_byte({1'b0, rd[6:0]}, {1'b0, q[k]});
      end
      $display("test lqi done");
   endtask
   task automatic test_ro();
      s0 = strobe_hits;
      wr_reg({2'b01, OFS_PART_ID}, 8'hff);
      rd_chk(OFS_PART_ID, PART_T);
      check_byte(8'(strobe_hits - s0), 8'h00);
      i_host_spi_model.frame({2'b00, OFS_WAKE_HIGH}, 8'h00, 0, rd);
      check_byte(8'(strobe_hits - s0), 8'h01);
      check_byte({2'b00, ctrl.strobe_code}, {2'b00, OFS_WAKE_HIGH});
      $display("test ro done");
   endtask
   task automatic report_and_stop();
      $display("counts tests_run=%0d bad_count=%0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
      report_and_stop();
   end
   initial
   begin
      ref_clk = 1'b0;
      rst = 1'b1;
      stat = '0;
      bad_count = 0;
      tests_run = 0;
      repeat (2) tick();
      rst = 1'b0;
      repeat (4) tick();
      test_reset();
      test_ids();
      test_freq();
      test_fields();
      test_states();
      test_crc();
      test_lqi();
      test_ro();
      report_and_stop();
   end
endmodule
`default_nettype wire
